// ==== design/cfs_pkg.sv ====
`default_nettype none
package cfs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_FILE = 8'h04;
  localparam logic [7:0] OFF_LCSI = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam logic [7:0] OFF_FWR = 8'h14;
  localparam logic [7:0] OFF_PIN = 8'h18;
  localparam logic [7:0] OFF_PINRES = 8'h1c;
  localparam logic [7:0] OFF_SFR = 8'h20;
  // command register fields
  localparam int CMD_P2_LSB = 0;
  localparam int CMD_P1_LSB = 8;
  localparam int CMD_LE_LSB = 16;
  localparam int CMD_KIND_BIT = 24;
  // file configuration fields
  localparam int FILE_FID_LSB = 0;
  localparam int FILE_SFR_LSB = 16;
  localparam int FILE_SFR_PRESENT_BIT = 24;
  localparam int FILE_SFR_LEN_BIT = 25;
  localparam int FILE_READ_OK_BIT = 26;
  // file write and template feed fields
  localparam int FWR_DATA_LSB = 0;
  localparam int FWR_ADDR_LSB = 16;
  localparam int PIN_START_BIT = 8;
  // result register fields
  localparam int RES_SW_LSB = 0;
  localparam int RES_APP_LSB = 16;
  localparam int RES_KIND_LSB = 18;
  localparam int RES_REMAIN_LSB = 20;
  // reset values
  localparam logic [15:0] RST_FID = 16'h0000;
  localparam logic [15:0] RST_SW = 16'h9000;
  // data object tags
  localparam logic [7:0] TAG_SFR = 8'h88;
  localparam logic [7:0] TAG_LCSI = 8'h8a;
  localparam logic [7:0] TAG_PIN_TMPL = 8'hc6;
  localparam logic [7:0] TAG_PS = 8'h90;
  localparam logic [7:0] TAG_UQ = 8'h95;
  localparam logic [7:0] TAG_KEYREF = 8'h83;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] KEY_UNIVERSAL = 8'h11;
  // status command parameters
  localparam logic [7:0] P1_NO_IND = 8'h00;
  localparam logic [7:0] P1_APP_INIT = 8'h01;
  localparam logic [7:0] P1_APP_TERM = 8'h02;
  localparam logic [7:0] P2_AS_SELECT = 8'h00;
  localparam logic [7:0] P2_APP_NAME = 8'h01;
  localparam logic [7:0] P2_NO_DATA = 8'h0c;
  // status words
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_SECURITY = 16'h6982;
  localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
  localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
  localparam logic [15:0] SW_BAD_OFFSET = 16'h6b00;
  localparam logic [8:0] LE_ZERO_LEN = 9'h100;

  typedef enum logic [2:0] {
    LC_NONE, LC_CREATION, LC_INIT, LC_OP_ACTIVE, LC_OP_INACTIVE,
    LC_TERMINATED, LC_PROPRIETARY, LC_RFU
  } cfs_lcsi_t;

  typedef enum logic [1:0] {
    RK_NONE, RK_SELECT, RK_APP_NAME, RK_FILE_DATA
  } cfs_resp_kind_t;
endpackage
`default_nettype wire

// ==== design/cfs_tlv_if.sv ====
`default_nettype none
interface cfs_tlv_if;
  import cfs_pkg::*;
  logic pin_start;
  logic pin_valid;
  logic [7:0] pin_byte;
  logic pin_done;
  logic pin_err;
  logic [3:0] key_count;
  logic [7:0] key_enabled;
  logic [7:0] key_qualified;
  logic [7:0] lcsi_byte;
  cfs_lcsi_t lcsi_state;

  modport ctrl (
    output pin_start, pin_valid, pin_byte, lcsi_byte,
    input pin_done, pin_err, key_count, key_enabled, key_qualified,
    input lcsi_state
  );
  modport pin (
    input pin_start, pin_valid, pin_byte,
    output pin_done, pin_err, key_count, key_enabled, key_qualified
  );
  modport lcsi (
    input lcsi_byte,
    output lcsi_state
  );
endinterface
`default_nettype wire

// ==== design/cfs_lcsi_decode.sv ====
`default_nettype none
module cfs_lcsi_decode
  import cfs_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  cfs_tlv_if.lcsi tif // life cycle byte in, class out
);
  typedef struct packed {
    cfs_lcsi_t state;
  } cfs_lcsi_st_t;

  cfs_lcsi_st_t st_reg;
  cfs_lcsi_st_t st_next;
  logic [7:0] b;

  always_comb
  begin
    b = tif.lcsi_byte;
    st_next = st_reg;
    if (b == 8'h00)
      st_next.state = LC_NONE; // R4
    else if (b == 8'h01)
      st_next.state = LC_CREATION; // R4
    else if (b == 8'h03)
      st_next.state = LC_INIT; // R4
    else if (b[7:3] == 5'h00 && b[2])
      // b2 plays no part in the operational states
      st_next.state = b[0] ? LC_OP_ACTIVE : LC_OP_INACTIVE; // R5
    else if (b[7:2] == 6'h03)
      st_next.state = LC_TERMINATED; // R4
    else if (b[7:4] != 4'h0)
      st_next.state = LC_PROPRIETARY; // R4
    else
      st_next.state = LC_RFU; // R4
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tif.lcsi_state = st_reg.state;
endmodule
`default_nettype wire

// ==== design/cfs_pin_parser.sv ====
`default_nettype none
module cfs_pin_parser
  import cfs_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  cfs_tlv_if.pin tif // template byte stream and results
);
  typedef enum logic [3:0] {
    P_TAG, P_LEN, P_PSTAG, P_PSLEN, P_PSVAL, P_OBJTAG, P_UQLEN, P_UQVAL,
    P_KTAG, P_KLEN, P_KVAL, P_DONE, P_ERR
  } cfs_pstate_t;

  typedef struct packed {
    cfs_pstate_t state;
    logic [7:0] remain;
    logic [7:0] cnt;
    logic ps_got;
    logic [7:0] ps;
    logic [3:0] idx;
    logic [7:0] en;
    logic [7:0] qual;
    logic uq_seen;
  } cfs_pin_st_t;

  cfs_pin_st_t st_reg;
  cfs_pin_st_t st_next;
  logic [7:0] b;

  always_comb
  begin
    b = tif.pin_byte;
    st_next = st_reg;
    if (tif.pin_start)
      st_next = '0;
    else if (tif.pin_valid)
    begin
      if (st_reg.state != P_TAG && st_reg.state != P_LEN)
        st_next.remain = st_reg.remain - 8'h01;
      case (st_reg.state)
        P_TAG: st_next.state = (b == TAG_PIN_TMPL) ? P_LEN : P_ERR; // R6
        P_LEN:
        begin
          st_next.remain = b; // R6
          st_next.state = (b == 8'h00) ? P_ERR : P_PSTAG;
        end
        P_PSTAG: st_next.state = (b == TAG_PS) ? P_PSLEN : P_ERR; // R6
        P_PSLEN:
        begin
          st_next.cnt = b;
          st_next.state = (b == 8'h00) ? P_ERR : P_PSVAL;
        end
        P_PSVAL:
        begin
          if (!st_reg.ps_got)
            st_next.ps = b;
          st_next.ps_got = 1'b1;
          st_next.cnt = st_reg.cnt - 8'h01;
          if (st_reg.cnt == 8'h01)
            st_next.state = P_OBJTAG;
        end
        P_OBJTAG:
        begin
          if (b == TAG_UQ)
            st_next.state = P_UQLEN; // R7
          else if (b == TAG_KEYREF)
            st_next.state = P_KLEN; // R9
          else
            st_next.state = P_ERR;
        end
        P_UQLEN: st_next.state = (b == LEN_ONE) ? P_UQVAL : P_ERR; // R7
        P_UQVAL:
        begin
          st_next.uq_seen = 1'b1;
          st_next.state = P_KTAG;
        end
        // a qualifier must sit right before its key reference
        P_KTAG: st_next.state = (b == TAG_KEYREF) ? P_KLEN : P_ERR; // R7
        P_KLEN: st_next.state = (b == LEN_ONE) ? P_KVAL : P_ERR;
        P_KVAL:
        begin
          if ((b == KEY_UNIVERSAL && !st_reg.uq_seen) || st_reg.idx[3]) // R8
            st_next.state = P_ERR;
          else
          begin
            // first key pairs with b8 of the status byte
            st_next.en[st_reg.idx[2:0]] =
              st_reg.ps[3'd7 - st_reg.idx[2:0]]; // R10
            st_next.qual[st_reg.idx[2:0]] = st_reg.uq_seen;
            st_next.idx = st_reg.idx + 4'h1; // R9
            st_next.uq_seen = 1'b0;
            st_next.state = P_OBJTAG;
          end
        end
        default: st_next.state = P_ERR;
      endcase
      // template length closes the object only on a boundary
      if (st_reg.state != P_TAG && st_reg.state != P_LEN &&
          st_reg.state != P_ERR && st_next.remain == 8'h00)
        st_next.state = (st_next.state == P_OBJTAG) ? P_DONE : P_ERR; // R6
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tif.pin_done = (st_reg.state == P_DONE);
  assign tif.pin_err = (st_reg.state == P_ERR);
  assign tif.key_count = st_reg.idx;
  assign tif.key_enabled = st_reg.en;
  assign tif.key_qualified = st_reg.qual;
endmodule
`default_nettype wire

// ==== design/cfs_file_status_top.sv ====
// Notes on behaviour
// R1 - no reference object: short_file_ref is file identifier bits b5..b1
// R2 - reference object of length zero: file not addressable by short_file_ref
// R3 - reference object length one: reference in b8..b4, b3..b1 zero
// R4 - life cycle byte: none, creation, init, termination, proprietary, reserved
// R5 - upper five zero with b3 set: operational, b1 picks active
// R6 - pin template tag c6 opens with pin status byte object tag 90
// R7 - usage qualifier 95 length 01 immediately precedes its key reference
// R8 - qualifier mandatory before universal pin key reference 11
// R9 - each pin is a key reference 83; count equals pins in use
// R10 - status byte bit set enables key reference in the same order
// R11 - status P1: 00 nothing, 01 application initialised, 02 terminating
// R12 - status P2: 00 as select, 01 application name, 0c no data
// R13 - terminal sends Le empty, 00, or its maximum expected length
// R14 - binary read only when the file read condition is satisfied
// R15 - P1 b8 clear: offset is P1 b7..b1 high, P2 low
// R16 - P1 b8..b6 = 100: short_file_ref in b5..b1, P2 is offset
// R17 - binary read has no command data and returns exactly Le bytes
// R18 - P1 b8 set with b7 or b6 set: error, no read, no change
`default_nettype none
module cfs_file_status_top
  import cfs_pkg::*;
#(
  parameter int FILE_BYTES = 256
)
(
  input wire logic pclk, // clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error, unmapped address
);
  localparam int AW = (FILE_BYTES > 1) ? $clog2(FILE_BYTES) : 1;
  localparam logic [16:0] FILE_LIMIT = 17'(FILE_BYTES);

  if (FILE_BYTES < 2 || FILE_BYTES > 32768)
  begin
    $error("FILE_BYTES must lie between 2 and 32768");
  end

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] fid;
    logic [7:0] sfr_byte;
    logic sfr_present;
    logic sfr_len1;
    logic read_ok;
    logic [7:0] lcsi_byte;
    logic [15:0] sw;
    logic [1:0] app_ind;
    cfs_resp_kind_t resp_kind;
    logic [8:0] remain;
    logic [14:0] ptr;
    logic pin_start;
    logic pin_valid;
    logic [7:0] pin_byte;
  } cfs_top_st_t;

  cfs_top_st_t st_reg;
  cfs_top_st_t st_next;
  logic [7:0] file_mem [FILE_BYTES];
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic setup_done;
  logic finish;
  logic [6:0] sfr_now;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [8:0] len;
  logic [14:0] off;
  logic [15:0] rb_sw;
  logic [15:0] fwr_addr;

  cfs_tlv_if tif();

  // {malformed, supported, reference} for the current file
  function automatic logic [6:0] sfr_eval(
    input logic present,
    input logic len1,
    input logic [7:0] val,
    input logic [15:0] fid
  );
    logic [6:0] r;
    r = '0;
    if (!present)
      r = {2'b01, fid[4:0]}; // R1
    else if (!len1)
      r = 7'h00; // R2
    else
      r = {(val[2:0] != 3'b000), 1'b1, val[7:3]}; // R3
    return r;
  endfunction

  cfs_lcsi_decode u_lcsi (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif.lcsi)
  );

  cfs_pin_parser u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif.pin)
  );

  assign tif.pin_start = st_reg.pin_start;
  assign tif.pin_valid = st_reg.pin_valid;
  assign tif.pin_byte = st_reg.pin_byte;
  assign tif.lcsi_byte = st_reg.lcsi_byte;

  assign mem_rdata = file_mem[st_reg.ptr[AW-1:0]];

  always_comb
  begin
    st_next = st_reg;
    mem_we = 1'b0;
    mem_addr = '0;
    mem_wdata = '0;
    setup_done = psel && penable && !st_reg.pready;
    finish = psel && penable && st_reg.pready;
    sfr_now = sfr_eval(st_reg.sfr_present, st_reg.sfr_len1,
                       st_reg.sfr_byte, st_reg.fid);
    p1 = pwdata[CMD_P1_LSB +: 8];
    p2 = pwdata[CMD_P2_LSB +: 8];
    // Le of zero asks for the full 256 bytes
    len = (pwdata[CMD_LE_LSB +: 8] == 8'h00) ? LE_ZERO_LEN
          : {1'b0, pwdata[CMD_LE_LSB +: 8]};
    off = '0;
    rb_sw = SW_OK;
    fwr_addr = pwdata[FWR_ADDR_LSB +: 16];
    st_next.pin_start = 1'b0;
    st_next.pin_valid = 1'b0;

    // binary read decode, used when a command write completes
    if (p1[7] && p1[6:5] != 2'b00)
      rb_sw = SW_BAD_P1P2; // R18
    else if (!st_reg.read_ok)
      rb_sw = SW_SECURITY; // R14
    else if (!p1[7])
      off = {p1[6:0], p2}; // R15
    else
    begin
      off = {7'h00, p2}; // R16
      if (!sfr_now[5] || sfr_now[6] || sfr_now[4:0] != p1[4:0])
        rb_sw = SW_NOT_FOUND; // R16
    end
    if (rb_sw == SW_OK && ({2'b00, off} + {8'h00, len}) > FILE_LIMIT)
      rb_sw = SW_BAD_OFFSET;

    if (setup_done)
    begin
      st_next.pready = 1'b1;
      st_next.pslverr = 1'b0;
      st_next.prdata = '0;
      if (paddr == OFF_CMD)
        st_next.prdata = '0;
      else if (paddr == OFF_FILE)
        st_next.prdata = {5'h00, st_reg.read_ok, st_reg.sfr_len1,
                          st_reg.sfr_present, st_reg.sfr_byte, st_reg.fid};
      else if (paddr == OFF_LCSI)
        st_next.prdata = {21'h0, tif.lcsi_state, st_reg.lcsi_byte};
      else if (paddr == OFF_RESULT)
        st_next.prdata = {3'h0, st_reg.remain, st_reg.resp_kind,
                          st_reg.app_ind, st_reg.sw};
      else if (paddr == OFF_DATA)
        st_next.prdata = (st_reg.remain != 9'h000) ? {24'h0, mem_rdata}
                         : 32'h0;
      else if (paddr == OFF_FWR || paddr == OFF_PIN)
        st_next.prdata = '0;
      else if (paddr == OFF_PINRES)
        st_next.prdata = {10'h0, tif.pin_err, tif.pin_done, tif.key_count,
                          tif.key_qualified, tif.key_enabled};
      else if (paddr == OFF_SFR)
        st_next.prdata = {25'h0, sfr_now};
      else
        st_next.pslverr = 1'b1;
    end
    else if (finish)
    begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      if (pwrite)
      begin
        if (paddr == OFF_CMD)
        begin
          if (pwdata[CMD_KIND_BIT])
          begin
            // no command data field exists for a binary read
            st_next.sw = rb_sw;
            st_next.resp_kind = (rb_sw == SW_OK) ? RK_FILE_DATA : RK_NONE;
            st_next.ptr = (rb_sw == SW_OK) ? off : st_reg.ptr;
            st_next.remain = (rb_sw == SW_OK) ? len : 9'h000; // R17
          end
          else
          begin
            st_next.remain = 9'h000;
            st_next.resp_kind = RK_NONE;
            st_next.sw = SW_OK;
            if (p1 == P1_NO_IND || p1 == P1_APP_INIT || p1 == P1_APP_TERM)
              st_next.app_ind = p1[1:0]; // R11
            else
              st_next.sw = SW_BAD_P1P2;
            if (st_next.sw == SW_OK)
            begin
              if (p2 == P2_AS_SELECT)
                st_next.resp_kind = RK_SELECT; // R12
              else if (p2 == P2_APP_NAME)
                st_next.resp_kind = RK_APP_NAME; // R12
              else if (p2 == P2_NO_DATA)
                st_next.resp_kind = RK_NONE; // R12
              else
                st_next.sw = SW_BAD_P1P2; // R12
            end
          end
        end
        else if (paddr == OFF_FILE)
        begin
          st_next.fid = pwdata[FILE_FID_LSB +: 16];
          st_next.sfr_byte = pwdata[FILE_SFR_LSB +: 8];
          st_next.sfr_present = pwdata[FILE_SFR_PRESENT_BIT];
          st_next.sfr_len1 = pwdata[FILE_SFR_LEN_BIT];
          st_next.read_ok = pwdata[FILE_READ_OK_BIT];
        end
        else if (paddr == OFF_LCSI)
          st_next.lcsi_byte = pwdata[7:0];
        else if (paddr == OFF_FWR)
        begin
          mem_we = ({1'b0, fwr_addr} < FILE_LIMIT);
          mem_addr = fwr_addr[AW-1:0];
          mem_wdata = pwdata[FWR_DATA_LSB +: 8];
        end
        else if (paddr == OFF_PIN)
        begin
          st_next.pin_start = pwdata[PIN_START_BIT];
          st_next.pin_valid = !pwdata[PIN_START_BIT];
          st_next.pin_byte = pwdata[7:0];
        end
      end
      else if (paddr == OFF_DATA && st_reg.remain != 9'h000)
      begin
        // each data read hands out the next byte of the response
        st_next.ptr = st_reg.ptr + 15'h0001; // R17
        st_next.remain = st_reg.remain - 9'h001; // R17
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.fid <= RST_FID;
      st_reg.sw <= RST_SW;
    end
    else
      st_reg <= st_next;
  end

  // file contents carry no reset
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      file_mem[mem_addr] <= mem_wdata;
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
endmodule
`default_nettype wire

// ==== sim/cfs_file_status_assertions.sv ====
`default_nettype none
module cfs_file_status_assertions
  import cfs_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd, st, bn, p2ok;
  logic [31:0] fil, cmd;
  logic [7:0] p1, p2;
  logic [1:0] rk;
  assign rd = psel && penable && pready && !pwrite && !pslverr;
  assign p1 = cmd[15:8];
  assign p2 = cmd[7:0];
  assign st = cmd[25] && !cmd[24] && p1 <= P1_APP_TERM;
  assign bn = cmd[25] && cmd[24];
  assign p2ok = p2 == P2_AS_SELECT || p2 == P2_APP_NAME || p2 == P2_NO_DATA;
  assign rk = p2 == P2_AS_SELECT ? RK_SELECT : RK_APP_NAME;
  // last file setup and last command, with the access bit of that moment
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fil <= '0;
      cmd <= '0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == OFF_FILE) fil <= pwdata;
      if (paddr == OFF_CMD) cmd <= {5'h0, fil[26], 1'b1, pwdata[24:0]};
    end
  function automatic logic [2:0] lc(logic [7:0] b);
    if (b[7:4] != 4'h0) return LC_PROPRIETARY;
    if (b[3:2] == 2'b11) return LC_TERMINATED;
    if (b[3]) return LC_RFU;
    if (b[2]) return b[0] ? LC_OP_ACTIVE : LC_OP_INACTIVE;
    if (b[1:0] == 2'b00) return LC_NONE;
    if (b[1:0] == 2'b01) return LC_CREATION;
    return b[0] ? LC_INIT : LC_RFU;
  endfunction
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_SFR_FROM_FID: assert property (
    rd && paddr == OFF_SFR && !fil[24] |-> prdata[5:0] == {1'b1, fil[4:0]}
  ) else $error("short ref not from file id");
  AST_SFR_EMPTY: assert property (
    rd && paddr == OFF_SFR && fil[25:24] == 2'b01 |-> !prdata[5]
  ) else $error("empty reference reported usable");
  AST_SFR_VALUE: assert property (
    rd && paddr == OFF_SFR && fil[25:24] == 2'b11 |->
      prdata[4:0] == fil[23:19] && prdata[6] == (fil[18:16] != 3'h0)
  ) else $error("short ref value wrong");
  AST_LC_CLASS: assert property (
    rd && paddr == OFF_LCSI && prdata[7:2] != 6'h01 |->
      prdata[10:8] == lc(prdata[7:0])
  ) else $error("life cycle class wrong");
  AST_LC_OPER: assert property (
    rd && paddr == OFF_LCSI && prdata[7:2] == 6'h01 |->
      prdata[10:8] == (prdata[0] ? 3'd3 : 3'd4)
  ) else $error("operational class wrong");
  AST_APP_IND: assert property (
    rd && paddr == OFF_RESULT && st |-> prdata[17:16] == p1[1:0]
  ) else $error("application indication wrong");
  AST_STATUS_P2: assert property (
    rd && paddr == OFF_RESULT && st |->
      prdata[15:0] == (p2ok ? SW_OK : SW_BAD_P1P2) &&
      (!p2ok || p2 == P2_NO_DATA || prdata[19:18] == rk)
  ) else $error("status response wrong");
  AST_READ_DENIED: assert property (
    rd && paddr == OFF_RESULT && bn && !(p1[7] && p1[6:5] != 2'b00) &&
      !cmd[26] |-> prdata[15:0] == SW_SECURITY && prdata[28:20] == 9'h0
  ) else $error("read without access");
  AST_BAD_REF_FORM: assert property (
    rd && paddr == OFF_RESULT && bn && p1[7] && p1[6:5] != 2'b00 |->
      prdata[15:0] == SW_BAD_P1P2 && prdata[28:20] == 9'h0
  ) else $error("bad reference form accepted");
endmodule

bind cfs_file_status_top cfs_file_status_assertions u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr
);
`default_nettype wire

// ==== sim/cfs_terminal.sv ====
`default_nettype none
module cfs_terminal
  import cfs_pkg::*;
(
  input wire logic pclk, // clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [7:0] paddr, // address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic issue(logic w, logic [7:0] a, logic [31:0] d,
    output logic [31:0] q, output logic e, output logic h);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    q = prdata;
    e = pslverr;
    h = pready !== 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines do not keep the last value
    pwdata <= ~d;
  endtask
  // an empty length field goes out as 00, asking for 256 bytes
  function automatic logic [31:0] cmd_word(logic bin, logic [7:0] p1,
    logic [7:0] p2, logic [7:0] le);
    return {7'h0, bin, le, p1, p2};
  endfunction
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none
module testbench
  import cfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_errors = 0;
  int cmp_count = 0;
  cfs_file_status_top #(.FILE_BYTES(64)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr
  );
  cfs_terminal term (
    .pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr
  );
  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic err,
    output logic [31:0] q);
    logic e, h;
    term.issue(w, a, d, q, e, h);
    if (h)
    begin
      n_errors++;
      give_verdict();
    end
    chk(e, err);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 1'b0, q);
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, 1'b0, q);
  endtask
  task automatic s_basic();
    logic [31:0] q;
    rd(OFF_RESULT, q);
    chk(q[15:0], RST_SW);
    xfer(1'b0, 8'h24, 32'h0, 1'b1, q);
    chk(q, 32'h0);
    xfer(1'b1, 8'h30, 32'hffff_ffff, 1'b1, q);
  endtask
  task automatic s_sfr();
    logic [31:0] q;
    wr(OFF_FILE, 32'h0400_1237);
    rd(OFF_SFR, q);
    chk(q[5:0], 6'h37);
    wr(OFF_FILE, 32'h0500_1237);
    rd(OFF_SFR, q);
    chk(q[5], 1'b0);
    wr(OFF_FILE, 32'h07aa_1237);
    rd(OFF_SFR, q);
    chk({q[6], q[4:0]}, 6'h35);
  endtask
  task automatic s_lcsi();
    logic [31:0] q;
    logic [7:0] b [12] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h04, 8'h06,
      8'h0c, 8'h0f, 8'h10, 8'h02, 8'h08, 8'hff};
    cfs_lcsi_t c [12] = '{LC_NONE, LC_CREATION, LC_INIT, LC_OP_ACTIVE,
      LC_OP_INACTIVE, LC_OP_INACTIVE, LC_TERMINATED, LC_TERMINATED,
      LC_PROPRIETARY, LC_RFU, LC_RFU, LC_PROPRIETARY};
    foreach (b[i])
    begin
      wr(OFF_LCSI, {24'h0, b[i]});
      rd(OFF_LCSI, q);
      chk(q[10:0], {c[i], b[i]});
    end
  endtask
  task automatic s_status();
    logic [31:0] q;
    logic [1:0] app = 2'h0;
    logic ok;
    logic [7:0] p1 [5] = '{8'h00, 8'h01, 8'h02, 8'h01, 8'h03};
    logic [7:0] p2 [5] = '{8'h00, 8'h01, 8'h0c, 8'h05, 8'h00};
    logic [7:0] le [5] = '{8'h00, 8'hff, 8'h10, 8'h00, 8'h20};
    cfs_resp_kind_t rk [5] = '{RK_SELECT, RK_APP_NAME, RK_NONE, RK_NONE,
      RK_NONE};
    foreach (p1[i])
    begin
      wr(OFF_CMD, term.cmd_word(1'b0, p1[i], p2[i], le[i]));
      rd(OFF_RESULT, q);
      ok = p1[i] <= 8'h02 && (p2[i] <= 8'h01 || p2[i] == 8'h0c);
      if (p1[i] <= 8'h02) app = p1[i][1:0];
      chk(q[28:0], {9'h000, rk[i], app, ok ? SW_OK : SW_BAD_P1P2});
    end
  endtask
  task automatic s_read();
    logic [31:0] q;
    int n;
    // last case: Le of 00 asks 256 bytes, more than the file holds
    logic [7:0] p1 [8] = '{8'h00, 8'h83, 8'h01, 8'h84, 8'ha3, 8'hc3, 8'h00,
      8'h00};
    logic [7:0] p2 [8] = '{8'h3c, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3e,
      8'h00};
    logic [7:0] le [8] = '{8'h04, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04,
      8'h00};
    logic [15:0] sw [8] = '{SW_OK, SW_OK, SW_BAD_OFFSET, SW_NOT_FOUND,
      SW_BAD_P1P2, SW_BAD_P1P2, SW_BAD_OFFSET, SW_BAD_OFFSET};
    for (int i = 0; i < 64; i++)
      wr(OFF_FWR, {16'(i), 8'h0, 8'(i) ^ 8'h5a});
    wr(OFF_FILE, 32'h0400_0003);
    foreach (p1[i])
    begin
      wr(OFF_CMD, term.cmd_word(1'b1, p1[i], p2[i], le[i]));
      rd(OFF_RESULT, q);
      chk(q[15:0], sw[i]);
      n = sw[i] == SW_OK ? int'(le[i]) : 0;
      chk(q[28:18], {n[8:0], sw[i] == SW_OK ? RK_FILE_DATA : RK_NONE});
      for (int j = 0; j <= n; j++)
      begin
        rd(OFF_DATA, q);
        chk(q, j < n ? {24'h0, 8'h5a ^ (p2[i] + 8'(j))} : 32'h0);
      end
    end
    wr(OFF_FILE, 32'h0000_0003);
    wr(OFF_CMD, term.cmd_word(1'b1, 8'h00, 8'h00, 8'h01));
    rd(OFF_RESULT, q);
    chk(q[15:0], SW_SECURITY);
  endtask
  task automatic s_pin();
    logic [31:0] q;
    logic [7:0] t [14] = '{8'hc6, 8'h0c, 8'h90, 8'h01, 8'h80, 8'h95, 8'h01,
      8'h08, 8'h83, 8'h01, 8'h11, 8'h83, 8'h01, 8'h01};
    logic [7:0] u [8] = '{8'hc6, 8'h06, 8'h90, 8'h01, 8'h80, 8'h83, 8'h01,
      8'h11};
    wr(OFF_PIN, 32'h100);
    foreach (t[i])
      wr(OFF_PIN, {24'h0, t[i]});
    rd(OFF_PINRES, q);
    chk(q, 32'h0012_0101);
    wr(OFF_PIN, 32'h100);
    foreach (u[i])
      wr(OFF_PIN, {24'h0, u[i]});
    rd(OFF_PINRES, q);
    chk(q[21], 1'b1);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    s_basic();
    s_sfr();
    s_lcsi();
    s_status();
    s_read();
    s_pin();
    give_verdict();
  end
endmodule
`default_nettype wire
